// [shm_pkg.sv]
/*
 * constants and carrier types of the handshake and mailbox block.
 * assumes one 20 MHz clock; register numbers are the addresses.
 */
package shm_pkg;

    localparam int NPORT = 2;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 13;
    localparam int CHAR_W = 8;

    localparam longint CLK_HZ = 64'd20_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = int'((CLK_HZ * TICK_MS) / 1000);

    localparam int MAILBOX_WORDS = 2048;
    localparam int RACK_IN_LAST = 32;
    localparam int RACK_LAST = 64;

    localparam logic [15:0] PAD_MIN = 16'h000a;

    localparam logic [12:0] ADDR_MBOX_FIRST = 13'h0001;
    localparam logic [12:0] ADDR_MBOX_LAST = 13'h0800;
    localparam logic [12:0] ADDR_P1_STAT = 13'h0818;
    localparam logic [12:0] ADDR_P2_STAT = 13'h0838;
    localparam logic [12:0] ADDR_P1_RADIO_DLY = 13'h1f6a;
    localparam logic [12:0] ADDR_P1_DLY_FILL = 13'h1f80;
    localparam logic [12:0] ADDR_P2_RADIO_DLY = 13'h1f8a;
    localparam logic [12:0] ADDR_P2_DLY_FILL = 13'h1fa0;

    localparam logic [15:0] RST_RADIO_DLY = 16'h0000;
    localparam logic [15:0] RST_DLY_FILL = 16'h000a;
    localparam logic [15:0] RST_STAT = 16'h0000;

    typedef enum logic [2:0] {
        MODE_FLOW = 3'b001,
        MODE_PTT = 3'b010,
        MODE_RADIO = 3'b100
    } shm_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_DRAIN = 3'b100
    } shm_state_t;

    typedef struct packed {
        logic valid;
        logic [CHAR_W-1:0] data;
    } shm_char_t;

    typedef struct packed {
        logic pktEnd;
        logic padSent;
        logic ackSeen;
    } shm_poll_ev_t;

endpackage

// [shm_mailbox_ram.sv]
/*
 * mailbox word store, two ports, registered reads.
 * assumes zero-based indices; port a wins a same-word write clash.
 */
module shm_mailbox_ram #(
    parameter int WORDS = 2048,
    parameter int WIDTH = 16,
    parameter int IDX_W = $clog2(WORDS)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic aWe,
    input wire logic [IDX_W-1:0] aIdx,
    input wire logic [WIDTH-1:0] aWdata,
    output logic [WIDTH-1:0] aRdata,
    input wire logic bWe,
    input wire logic [IDX_W-1:0] bIdx,
    input wire logic [WIDTH-1:0] bWdata,
    output logic [WIDTH-1:0] bRdata
);

    logic [WIDTH-1:0] mem [WORDS];

    if (WORDS < 2 || IDX_W < $clog2(WORDS)) begin : g_chk
        $error("mailbox geometry not supported");
    end

    // no reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (aWe) begin
            mem[aIdx] <= aWdata;
        end
        if (bWe && !(aWe && aIdx == bIdx)) begin
            mem[bIdx] <= bWdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aRdata <= '0;
            bRdata <= '0;
        end else begin
            aRdata <= mem[aIdx];
            bRdata <= mem[bIdx];
        end
    end

endmodule

// [shm_top.sv]
/*
 * two port handshake engines, config and statistic registers,
 * and the mailbox shared by register port and plc rack.
 * assumes txReady rises only at a character boundary
 * and that cts comes asynchronously from a pin.
 */
// Notes on behaviour
// - cts active: transmit as soon as a message is pending.
// - cts inactive or open: hold characters, send nothing.
// - push-to-talk modes wait a programmable delay after cts rises, 10 ms units.
// - radio network mode takes the delay from the radio delay register.
// - other push-to-talk modes take the delay from the delay/filler register.
// - flow-control modes: rts active, inactive only while buffers back up.
// - push-to-talk modes: rts idle low, high from pending until all sent.
// - polling modes send filler characters before enq; fewer than 10 means 10.
// - filler count comes from the delay/filler register.
// - statistic register: bytes between checksum and acknowledge.
// - rack sees mailbox 1..64: 1..32 plc inputs, 33..64 plc outputs.
// - plc output writes land in mailbox, readable through the ports.
// - ports reach mailbox registers 1 through 2048.
module shm_top #(
    parameter int TICK_CYCLES = shm_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input shm_pkg::shm_mode_t portMode [shm_pkg::NPORT],
    input wire logic [shm_pkg::NPORT-1:0] pollProto,
    input wire logic [shm_pkg::NPORT-1:0] ctsPin,
    output logic [shm_pkg::NPORT-1:0] rtsOut,
    input wire logic [shm_pkg::NPORT-1:0] bufBackup,
    input wire logic [shm_pkg::NPORT-1:0] msgPending,
    input shm_pkg::shm_char_t inChar [shm_pkg::NPORT],
    output logic [shm_pkg::NPORT-1:0] inReady,
    output shm_pkg::shm_char_t txChar [shm_pkg::NPORT],
    input wire logic [shm_pkg::NPORT-1:0] txReady,
    input shm_pkg::shm_poll_ev_t pollEv [shm_pkg::NPORT],
    output logic [shm_pkg::NPORT-1:0] padNeeded,
    output logic [shm_pkg::NPORT-1:0] enqReq,
    input wire logic regReq,
    input wire logic regWe,
    input wire logic [shm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [shm_pkg::DATA_W-1:0] regWdata,
    output logic [shm_pkg::DATA_W-1:0] regRdata,
    output logic regAck,
    output logic regErr,
    input wire logic rackReq,
    input wire logic rackWe,
    input wire logic [6:0] rackAddr,
    input wire logic [shm_pkg::DATA_W-1:0] rackWdata,
    output logic [shm_pkg::DATA_W-1:0] rackRdata,
    output logic rackAck,
    output logic rackErr
);

    localparam int IDX_W = $clog2(shm_pkg::MAILBOX_WORDS);

    if (TICK_CYCLES < 1 || shm_pkg::NPORT != 2
            || shm_pkg::MAILBOX_WORDS < shm_pkg::RACK_LAST) begin : g_chk
        $error("unsupported tick or mailbox parameters");
    end

    // shared 10 ms tick enable
    logic [31:0] tickCnt_r;
    logic tick;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_r <= '0;
        end else if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= tickCnt_r + 32'h0000_0001;
        end
    end

    assign tick = (tickCnt_r == 32'(TICK_CYCLES - 1));

    // config and statistic storage
    logic [shm_pkg::DATA_W-1:0] radioDly_r [shm_pkg::NPORT];
    logic [shm_pkg::DATA_W-1:0] dlyFill_r [shm_pkg::NPORT];
    logic [shm_pkg::DATA_W-1:0] stat_r [shm_pkg::NPORT];

    // register port decode
    logic regMbox;
    logic [IDX_W-1:0] regIdx;
    logic [shm_pkg::NPORT-1:0] hitRadio;
    logic [shm_pkg::NPORT-1:0] hitFill;
    logic [shm_pkg::NPORT-1:0] hitStat;
    logic regHit;

    assign regMbox = (regAddr >= shm_pkg::ADDR_MBOX_FIRST)
                  && (regAddr <= shm_pkg::ADDR_MBOX_LAST);
    assign regIdx = IDX_W'(regAddr - shm_pkg::ADDR_MBOX_FIRST);
    assign hitRadio[0] = (regAddr == shm_pkg::ADDR_P1_RADIO_DLY);
    assign hitRadio[1] = (regAddr == shm_pkg::ADDR_P2_RADIO_DLY);
    assign hitFill[0] = (regAddr == shm_pkg::ADDR_P1_DLY_FILL);
    assign hitFill[1] = (regAddr == shm_pkg::ADDR_P2_DLY_FILL);
    assign hitStat[0] = (regAddr == shm_pkg::ADDR_P1_STAT);
    assign hitStat[1] = (regAddr == shm_pkg::ADDR_P2_STAT);
    assign regHit = regMbox || (|hitRadio) || (|hitFill) || (|hitStat);

    // rack decode: outputs only are writable by the plc
    logic rackIn;
    logic rackOut;
    logic [IDX_W-1:0] rackIdx;

    assign rackIn = (rackAddr >= 7'h01) && (rackAddr <= 7'(shm_pkg::RACK_IN_LAST));
    assign rackOut = (rackAddr > 7'(shm_pkg::RACK_IN_LAST))
                  && (rackAddr <= 7'(shm_pkg::RACK_LAST));
    assign rackIdx = IDX_W'(rackAddr - 7'h01);

    logic [shm_pkg::DATA_W-1:0] mboxA;
    logic [shm_pkg::DATA_W-1:0] mboxB;

    shm_mailbox_ram #(
        .WORDS(shm_pkg::MAILBOX_WORDS),
        .WIDTH(shm_pkg::DATA_W),
        .IDX_W(IDX_W)
    ) u_mbox (
        .clk(clk),
        .rstn(rstn),
        .aWe(regReq && regWe && regMbox),
        .aIdx(regIdx),
        .aWdata(regWdata),
        .aRdata(mboxA),
        .bWe(rackReq && rackWe && rackOut),
        .bIdx(rackIdx),
        .bWdata(rackWdata),
        .bRdata(mboxB)
    );

    // register port answer, one cycle after the request
    logic regFromMbox_r;
    logic [shm_pkg::DATA_W-1:0] regHold_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regAck <= 1'b0;
            regErr <= 1'b0;
            regFromMbox_r <= 1'b0;
            regHold_r <= '0;
        end else begin
            regAck <= regReq;
            regErr <= regReq && !regHit;
            regFromMbox_r <= regReq && regMbox;
            if (regReq) begin
                regHold_r <= '0;
                for (int p = 0; p < shm_pkg::NPORT; p++) begin
                    if (hitRadio[p]) begin
                        regHold_r <= radioDly_r[p];
                    end
                    if (hitFill[p]) begin
                        regHold_r <= dlyFill_r[p];
                    end
                    if (hitStat[p]) begin
                        regHold_r <= stat_r[p];
                    end
                end
            end
        end
    end

    assign regRdata = regFromMbox_r ? mboxA : regHold_r;

    // rack answer
    logic rackValid_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rackAck <= 1'b0;
            rackErr <= 1'b0;
            rackValid_r <= 1'b0;
        end else begin
            rackAck <= rackReq;
            rackErr <= rackReq && !(rackIn || rackOut);
            rackValid_r <= rackReq && (rackIn || rackOut);
        end
    end

    assign rackRdata = rackValid_r ? mboxB : '0;

    // per port handshake engines
    for (genvar i = 0; i < shm_pkg::NPORT; i++) begin : g_port

        // config writes; statistics are read only
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                radioDly_r[i] <= shm_pkg::RST_RADIO_DLY;
                dlyFill_r[i] <= shm_pkg::RST_DLY_FILL;
            end else if (regReq && regWe) begin
                if (hitRadio[i]) begin
                    radioDly_r[i] <= regWdata;
                end
                if (hitFill[i]) begin
                    dlyFill_r[i] <= regWdata;
                end
            end
        end

        // cts synchroniser; only an agreed pair updates the level
        logic ctsS1_r;
        logic ctsS2_r;
        logic ctsS3_r;
        logic cts_r;
        logic ctsRise;

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                ctsS1_r <= 1'b0;
                ctsS2_r <= 1'b0;
                ctsS3_r <= 1'b0;
                cts_r <= 1'b0;
            end else begin
                ctsS1_r <= ctsPin[i];
                ctsS2_r <= ctsS1_r;
                ctsS3_r <= ctsS2_r;
                if (ctsS2_r == ctsS3_r) begin
                    cts_r <= ctsS3_r;
                end
            end
        end

        assign ctsRise = (ctsS2_r == ctsS3_r) && ctsS3_r && !cts_r;

        // cts to transmit delay in push-to-talk modes
        logic isPtt;
        logic [shm_pkg::DATA_W-1:0] dlySel;
        logic [shm_pkg::DATA_W-1:0] dlyCnt_r;
        logic ctsGo;

        assign isPtt = (portMode[i] == shm_pkg::MODE_PTT)
                    || (portMode[i] == shm_pkg::MODE_RADIO);
        assign dlySel = (portMode[i] == shm_pkg::MODE_RADIO) ? radioDly_r[i]
                                                            : dlyFill_r[i];

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                dlyCnt_r <= '0;
            end else if (ctsRise) begin
                dlyCnt_r <= isPtt ? dlySel : '0;
            end else if (tick && dlyCnt_r != '0) begin
                dlyCnt_r <= dlyCnt_r - 16'h0001;
            end
        end

        // delay granularity is one tick, so the first step may be short
        assign ctsGo = cts_r && (!isPtt || dlyCnt_r == '0);

        // one held character; launch only when the serializer is at a boundary
        logic held_r;
        logic [shm_pkg::CHAR_W-1:0] heldData_r;
        logic launch;

        assign inReady[i] = !held_r;
        assign launch = held_r && ctsGo && txReady[i];

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                held_r <= 1'b0;
                heldData_r <= '0;
            end else if (inChar[i].valid && !held_r) begin
                held_r <= 1'b1;
                heldData_r <= inChar[i].data;
            end else if (launch) begin
                held_r <= 1'b0;
            end
        end

        assign txChar[i] = '{valid: held_r && ctsGo, data: heldData_r};

        // rts state
        shm_pkg::shm_state_t st_r;
        shm_pkg::shm_state_t st_nxt;
        logic pending;

        assign pending = held_r || msgPending[i] || inChar[i].valid;

        always_comb begin
            st_nxt = st_r;
            case (st_r)
                shm_pkg::ST_IDLE: begin
                    if (pending) begin
                        st_nxt = shm_pkg::ST_ACTIVE;
                    end
                end
                shm_pkg::ST_ACTIVE: begin
                    if (!pending) begin
                        st_nxt = shm_pkg::ST_DRAIN;
                    end
                end
                shm_pkg::ST_DRAIN: begin
                    // last character still shifting until the serializer is ready
                    if (pending) begin
                        st_nxt = shm_pkg::ST_ACTIVE;
                    end else if (txReady[i]) begin
                        st_nxt = shm_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_nxt = shm_pkg::ST_IDLE;
                end
            endcase
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                st_r <= shm_pkg::ST_IDLE;
            end else begin
                st_r <= st_nxt;
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                rtsOut[i] <= 1'b0;
            end else if (isPtt) begin
                rtsOut[i] <= (st_nxt != shm_pkg::ST_IDLE);
            end else begin
                rtsOut[i] <= !bufBackup[i];
            end
        end

        // filler characters and channel delay statistic
        logic [shm_pkg::DATA_W-1:0] padLimit;
        logic [shm_pkg::DATA_W-1:0] padCnt_r;
        logic wait_r;
        logic padLast;

        assign padLimit = (dlyFill_r[i] < shm_pkg::PAD_MIN) ? shm_pkg::PAD_MIN
                                                           : dlyFill_r[i];
        assign padLast = wait_r && pollEv[i].padSent
                      && (padCnt_r + 16'h0001 >= padLimit);
        assign padNeeded[i] = pollProto[i] && wait_r && (padCnt_r < padLimit);

        // a new checksum in the ack cycle wins: the fresh wait starts
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                wait_r <= 1'b0;
                padCnt_r <= '0;
            end else if (pollEv[i].pktEnd) begin
                wait_r <= 1'b1;
                padCnt_r <= '0;
            end else if (pollEv[i].ackSeen) begin
                wait_r <= 1'b0;
            end else if (wait_r && pollEv[i].padSent && padCnt_r != 16'hffff) begin
                padCnt_r <= padCnt_r + 16'h0001;
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                enqReq[i] <= 1'b0;
            end else begin
                enqReq[i] <= pollProto[i] && padLast && !pollEv[i].ackSeen
                          && !pollEv[i].pktEnd;
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                stat_r[i] <= shm_pkg::RST_STAT;
            end else if (wait_r && pollEv[i].ackSeen && !pollEv[i].pktEnd) begin
                stat_r[i] <= padCnt_r;
            end
        end
    end

endmodule

// [shm_props.sv]
/*
 * port checks: bus answers, port 0 tx gating, rts and the filler floor.
 * assumes it is bound onto shm_top and sees only its ports.
 */
module shm_props (
    input wire logic clk,
    input wire logic rstn,
    input shm_pkg::shm_mode_t portMode [shm_pkg::NPORT],
    input wire logic [shm_pkg::NPORT-1:0] pollProto,
    input wire logic [shm_pkg::NPORT-1:0] ctsPin,
    input wire logic [shm_pkg::NPORT-1:0] rtsOut,
    input wire logic [shm_pkg::NPORT-1:0] bufBackup,
    input wire logic [shm_pkg::NPORT-1:0] msgPending,
    input shm_pkg::shm_char_t inChar [shm_pkg::NPORT],
    input wire logic [shm_pkg::NPORT-1:0] inReady,
    input shm_pkg::shm_char_t txChar [shm_pkg::NPORT],
    input wire logic [shm_pkg::NPORT-1:0] txReady,
    input shm_pkg::shm_poll_ev_t pollEv [shm_pkg::NPORT],
    input wire logic [shm_pkg::NPORT-1:0] enqReq,
    input wire logic regReq,
    input wire logic [shm_pkg::ADDR_W-1:0] regAddr,
    input wire logic regAck,
    input wire logic regErr,
    input wire logic rackReq,
    input wire logic [6:0] rackAddr,
    input wire logic rackAck,
    input wire logic rackErr
);
    logic [15:0] padCnt_r;
    logic ptt0;
    logic idle0;

    assign ptt0 = portMode[0] != shm_pkg::MODE_FLOW;
    assign idle0 = inReady[0] && !msgPending[0] && !inChar[0].valid && txReady[0];

    // saturates so a stuck wait cannot wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            padCnt_r <= 16'h0000;
        end else if (pollEv[0].pktEnd) begin
            padCnt_r <= 16'h0000;
        end else if (pollEv[0].padSent && padCnt_r != 16'hffff) begin
            padCnt_r <= padCnt_r + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_take;
        inChar[0].valid && inReady[0];
    endsequence
    // synchroniser needs up to four cycles, so eight gives margin
    sequence s_ctsGo;
        (ctsPin[0] && portMode[0] == shm_pkg::MODE_FLOW) [*8];
    endsequence
    sequence s_ctsOff;
        !ctsPin[0] [*6];
    endsequence

    a_reg_answer: assert property (regReq |=> regAck)
        else $error("reg ack missing");
    a_reg_unmapped: assert property (regReq && regAddr == 13'h0000 |=> regAck && regErr)
        else $error("reg zero accepted");
    a_rack_refuse: assert property (rackReq && (rackAddr == 7'h00 || rackAddr > 7'h40)
        |=> rackAck && rackErr)
        else $error("rack miss accepted");
    a_rack_window: assert property (rackReq && rackAddr != 7'h00 && rackAddr <= 7'h40
        |=> rackAck && !rackErr)
        else $error("rack hit refused");
    a_take_holds: assert property (s_take |=> !inReady[0])
        else $error("char not held");
    a_cts_go: assert property (s_ctsGo ##0 !inReady[0] |-> txChar[0].valid)
        else $error("char not offered");
    a_cts_hold: assert property (s_ctsOff |-> !txChar[0].valid)
        else $error("char offered without cts");
    // rstn in the antecedent skips the edge that still saw reset
    a_flow_rts: assert property (rstn && portMode[0] == shm_pkg::MODE_FLOW
        |=> rtsOut[0] != $past(bufBackup[0]))
        else $error("flow rts wrong");
    a_ptt_rise: assert property ((ptt0 && msgPending[0]) ##1 ptt0 |-> rtsOut[0])
        else $error("ptt rts low");
    a_ptt_idle: assert property ((ptt0 && idle0) ##1 ptt0 |-> !rtsOut[0])
        else $error("ptt rts high idle");
    a_enq_floor: assert property (enqReq[0] |-> pollProto[0] && padCnt_r >= 16'h000a)
        else $error("early enquiry");
endmodule

bind shm_top shm_props uProps (.*);

// [shm_peer_model.sv]
/*
 * modem or radio on one port: keys cts from rts, paces characters.
 * assumes the bench drives ctsAllow and slow.
 */
module shm_peer_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic rts,
    input wire logic flowMode,
    input wire logic ctsAllow,
    input wire logic slow,
    input wire logic txValid,
    output logic cts,
    output logic txRdy
);
    logic [2:0] lag_r;
    logic [2:0] busy_r;

    // push-to-talk peers key up only after rts; flow peers grant whenever allowed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lag_r <= 3'h0;
        end else if (!(rts || flowMode)) begin
            lag_r <= 3'h0;
        end else if (lag_r != 3'h7) begin
            lag_r <= lag_r + 3'h1;
        end
    end
    assign cts = ctsAllow && (lag_r > (slow ? 3'h4 : 3'h1));

    // one character time per launch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 3'h0;
        end else if (txValid && txRdy) begin
            busy_r <= slow ? 3'h5 : 3'h1;
        end else if (busy_r != 3'h0) begin
            busy_r <= busy_r - 3'h1;
        end
    end
    assign txRdy = busy_r == 3'h0;
endmodule

// [serial_handshake_mailbox_bench.sv]
/*
 * bench for registers, rack, tx gating, rts and polling.
 * assumes a peer model per port and shm_props bound to the design.
 */
module serial_handshake_mailbox_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 8;
    typedef struct packed {
        logic chk;
        logic err;
        logic [15:0] data;
    } shm_exp_t;
    logic clk, rstn, regReq, regWe, regAck, regErr, rackReq, rackWe, rackAck, rackErr;
    logic [12:0] regAddr;
    logic [6:0] rackAddr;
    logic [15:0] regWdata, regRdata, rackWdata, rackRdata;
    logic [1:0] pollProto, rtsOut, bufBackup, msgPending, inReady, padNeeded, enqReq;
    logic [1:0] ctsAllow, slow;
    wire logic [1:0] ctsPin, txReady;
    shm_pkg::shm_mode_t portMode [2];
    shm_pkg::shm_char_t inChar [2];
    shm_pkg::shm_char_t txChar [2];
    shm_pkg::shm_poll_ev_t pollEv [2];
    shm_exp_t regQ[$], rackQ[$];
    logic [7:0] txQ [2][$];
    int errTotal, checksDone, cyc, enqSeen;
    int launchCyc [2];
    logic [12:0] rAddr [6] = '{13'h1f6a, 13'h1f80, 13'h1f8a, 13'h1fa0, 13'h0818, 13'h0838};
    logic [15:0] rRst [6] = '{shm_pkg::RST_RADIO_DLY, shm_pkg::RST_DLY_FILL,
        shm_pkg::RST_RADIO_DLY, shm_pkg::RST_DLY_FILL, shm_pkg::RST_STAT, shm_pkg::RST_STAT};

    shm_top #(.TICK_CYCLES(TICK)) uut (.*);
    for (genvar p = 0; p < 2; p++) begin : gPeer
        shm_peer_model uPeer (.clk, .rstn, .rts(rtsOut[p]),
            .flowMode(portMode[p] == shm_pkg::MODE_FLOW), .ctsAllow(ctsAllow[p]),
            .slow(slow[p]), .txValid(txChar[p].valid), .cts(ctsPin[p]), .txRdy(txReady[p]));
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic stopTest();
        if (errTotal == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic busOp(input logic rk, input logic we, input logic [12:0] a,
            input logic [15:0] d, input logic c = 1'b0, input logic e = 1'b0,
            input logic [15:0] x = 16'h0000);
        @(posedge clk);
        if (rk) begin
            rackReq <= 1'b1;
            rackWe <= we;
            rackAddr <= a[6:0];
            rackWdata <= d;
            rackQ.push_back('{c, e, x});
        end else begin
            regReq <= 1'b1;
            regWe <= we;
            regAddr <= a;
            regWdata <= d;
            regQ.push_back('{c, e, x});
        end
        @(posedge clk);
        regReq <= 1'b0;
        rackReq <= 1'b0;
    endtask

    // valid stands until an edge sees inReady; a stale ready would drop the char
    task automatic sendChar(input int p, input logic [7:0] c);
        @(posedge clk);
        inChar[p] <= '{1'b1, c};
        txQ[p].push_back(c);
        do @(posedge clk); while (inReady[p] !== 1'b1);
        inChar[p] <= '{1'b0, 8'h00};
    endtask

    task automatic pulse(input shm_pkg::shm_poll_ev_t e);
        @(posedge clk);
        pollEv[0] <= e;
        @(posedge clk);
        pollEv[0] <= 3'h0;
    endtask

    always @(posedge clk) begin
        shm_exp_t e;
        cyc++;
        if (regAck === 1'b1) begin
            e = regQ.pop_front();
            chkb(regErr, e.err);
            if (e.chk) begin
                chk(regRdata, e.data);
            end
        end
        if (rackAck === 1'b1) begin
            e = rackQ.pop_front();
            chkb(rackErr, e.err);
            if (e.chk) begin
                chk(rackRdata, e.data);
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (txChar[p].valid === 1'b1 && txReady[p] === 1'b1) begin
                chk({8'h00, txChar[p].data}, {8'h00, txQ[p].pop_front()});
                launchCyc[p] = cyc;
            end
        end
        if (enqReq[0] === 1'b1) begin
            enqSeen++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        stopTest();
    end

    initial begin
        logic [15:0] v;
        int t0;
        int lim;
        rstn = 1'b0;
        {regReq, regWe, rackReq, rackWe} = 4'h0;
        {regAddr, rackAddr, regWdata, rackWdata} = '0;
        {pollProto, bufBackup, msgPending, slow} = 8'h00;
        ctsAllow = 2'h3;
        portMode = '{shm_pkg::MODE_FLOW, shm_pkg::MODE_FLOW};
        inChar = '{9'h000, 9'h000};
        pollEv = '{3'h0, 3'h0};
        void'($urandom(39));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        // stats ignore writes
        for (int i = 0; i < 6; i++) begin
            v = 16'($urandom);
            busOp(0, 0, rAddr[i], 16'h0000, 1, 0, rRst[i]);
            busOp(0, 1, rAddr[i], v);
            busOp(0, 0, rAddr[i], 16'h0000, 1, 0, (i < 4) ? v : rRst[i]);
        end
        busOp(0, 1, 13'h1f80, 16'h0001);
        busOp(0, 1, 13'h1f6a, 16'h0005);
        busOp(0, 0, 13'h0000, 16'h0000, 1, 1, 16'h0000);
        busOp(0, 1, 13'h0801, 16'h1234, 0, 1);
        v = 16'($urandom);
        busOp(0, 1, 13'h0800, v);
        busOp(0, 0, 13'h0800, 16'h0000, 1, 0, v);
        busOp(1, 1, 13'h0028, ~v);
        busOp(0, 0, 13'h0028, 16'h0000, 1, 0, ~v);
        busOp(0, 1, 13'h0020, v);
        busOp(1, 1, 13'h0020, ~v);
        busOp(1, 0, 13'h0020, 16'h0000, 1, 0, v);
        busOp(1, 0, 13'h0000, 16'h0000, 1, 1, 16'h0000);
        busOp(1, 0, 13'h0041, 16'h0000, 1, 1, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 3; k++) begin
                sendChar(p, 8'($urandom));
            end
        end
        slow[0] <= 1'b1;
        sendChar(0, 8'h3c);
        ctsAllow[0] <= 1'b0;
        sendChar(0, 8'h5a);
        repeat (20) @(posedge clk);
        chk(16'(txQ[0].size()), 16'h0001);
        ctsAllow[0] <= 1'b1;
        sendChar(0, 8'ha5);
        bufBackup[0] <= 1'b1;
        repeat (3) @(posedge clk);
        chkb(rtsOut[0], 1'b0);
        bufBackup[0] <= 1'b0;
        slow[0] <= 1'b0;
        repeat (3) @(posedge clk);
        chkb(rtsOut[0], 1'b1);
        for (int m = 0; m < 2; m++) begin
            portMode[0] <= m ? shm_pkg::MODE_RADIO : shm_pkg::MODE_PTT;
            repeat (12) @(posedge clk);
            chkb(rtsOut[0], 1'b0);
            msgPending[0] <= 1'b1;
            t0 = cyc;
            repeat (2) @(posedge clk);
            chkb(rtsOut[0], 1'b1);
            sendChar(0, 8'($urandom));
            msgPending[0] <= 1'b0;
            sendChar(0, 8'($urandom));
            repeat (12) @(posedge clk);
            chkb(rtsOut[0], 1'b0);
            // radio waits five ticks, plain push-to-talk one
            lim = launchCyc[0] - t0;
            chkb(m ? (lim >= 4 * TICK) : (lim < 6 * TICK), 1'b1);
        end
        portMode[0] <= shm_pkg::MODE_FLOW;
        pollProto[0] <= 1'b1;
        for (int f = 0; f < 2; f++) begin
            lim = f ? 12 : 10;
            busOp(0, 1, 13'h1f80, f ? 16'h000c : 16'h0001);
            pulse(3'h4);
            enqSeen = 0;
            for (int k = 1; k < lim; k++) begin
                pulse(3'h2);
            end
            repeat (2) @(posedge clk);
            chkb(padNeeded[0], 1'b1);
            pulse(3'h2);
            repeat (3) @(posedge clk);
            chkb(padNeeded[0], 1'b0);
            chk(16'(enqSeen), 16'h0001);
            pulse(3'h2);
            pulse(3'h2);
            pulse(3'h1);
            busOp(0, 0, 13'h0818, 16'h0000, 1, 0, 16'(lim + 2));
        end
        busOp(0, 1, 13'h1f80, 16'(lim + 12));
        repeat (40) @(posedge clk);
        chk(16'(regQ.size() + rackQ.size() + txQ[0].size() + txQ[1].size()), 16'h0000);
        stopTest();
    end
endmodule
